// ---- design/piu_pkg.sv ----
// Shared constants and types for the prioritized interrupt unit
package piu_pkg;
    // Register addresses on the special-function bus
    localparam logic [7:0] ADDR_PRIO_HIGH0 = 8'hb4;
    localparam logic [7:0] ADDR_PRIO_HIGH1 = 8'hb5;
    localparam logic [7:0] ADDR_PRIO_LOW0 = 8'hb8;
    localparam logic [7:0] ADDR_PRIO_LOW1 = 8'hb9;
    localparam logic [7:0] ADDR_EXT4_PEND = 8'hd8;
    localparam logic [7:0] ADDR_EXT4_TRIG = 8'he8;

    // Reset values and implemented-bit masks
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] MASK_PRIO0 = 8'h7f;
    localparam logic [7:0] MASK_PRIO1 = 8'h29;
    localparam logic [7:0] MASK_EXT4 = 8'h6f;
    localparam logic [1:0] TRIG_RESET = 2'h0;

    // Trigger field position and codes
    localparam int TRIG_MSB = 7;
    localparam int TRIG_LSB = 6;
    localparam logic [1:0] TRIG_LOW = 2'h0;
    localparam logic [1:0] TRIG_FALL = 2'h1;
    localparam logic [1:0] TRIG_RISE = 2'h2;
    localparam logic [1:0] TRIG_BOTH = 2'h3;

    // Bank 1 bit positions of the upper sources
    localparam int PRIO1_SPI_BIT = 0;
    localparam int PRIO1_EXT4_BIT = 3;
    localparam int PRIO1_PWM_BIT = 5;

    // Sources in polling order, lowest index polled first
    localparam int NUM_SRC = 10;
    localparam int SRC_EXT4 = 8;
    localparam logic [3:0] SRC_NMI = 4'ha;
    localparam int NUM_EXT4 = 8;

    // Ranks: 0 idle, 1..4 for levels 0..3, 5 for the overload NMI
    localparam int RANK_W = 3;
    localparam logic [2:0] RANK_NONE = 3'h0;
    localparam logic [2:0] RANK_L3 = 3'h4;
    localparam logic [2:0] RANK_NMI = 3'h5;

    localparam logic PIN_IDLE = 1'b1;

    // Vector addresses indexed by source, NMI last
    localparam logic [15:0] VEC_TABLE [0:10] = '{
        16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
        16'h0033, 16'h003b, 16'h0053, 16'h0063, 16'h007b};
    localparam logic [15:0] VEC_RESET = 16'h0000;

    // Call and return sequencer, Gray along the call path only
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'h0,
        SEQ_PUSH_LO = 3'h1,
        SEQ_PUSH_HI = 3'h3,
        SEQ_LOAD = 3'h2,
        SEQ_POP_HI = 3'h6,
        SEQ_POP_LO = 3'h7
    } piu_seq_t;
endpackage : piu_pkg

// ---- design/piu_ext4_chan.sv ----
// One shared external interrupt 4 channel: sampler and pending flag
`timescale 1ns/10ps
module piu_ext4_chan
    import piu_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sampleEn,
    input wire logic pinLevel,
    input wire logic [1:0] trigMode,
    input wire logic swWrite,
    input wire logic swData,
    output logic pending
);
    logic pinPrev_q;
    logic pending_q;
    logic pending_d;
    logic fallEvt;
    logic riseEvt;
    logic edgeEvt;

    // Compare this machine cycle's sample to the last one
    assign fallEvt = sampleEn & pinPrev_q & ~pinLevel;
    assign riseEvt = sampleEn & ~pinPrev_q & pinLevel;
    assign edgeEvt = (trigMode == TRIG_FALL) ? fallEvt :
                     (trigMode == TRIG_RISE) ? riseEvt :
                     (trigMode == TRIG_BOTH) ? (fallEvt | riseEvt) : 1'b0;
    // Level mode tracks the pin; an edge beats a software clear
    assign pending_d = (trigMode == TRIG_LOW) ? ~pinLevel :
                       edgeEvt ? 1'b1 :
                       swWrite ? swData : pending_q;
    assign pending = pending_q;

    // Sample and flag registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinPrev_q <= PIN_IDLE;
            pending_q <= 1'b0;
        end else begin
            if (sampleEn) begin
                pinPrev_q <= pinLevel;
            end
            pending_q <= pending_d;
        end
    end
endmodule : piu_ext4_chan

// ---- design/piu_core.sv ----
// Prioritized interrupt unit: priority registers, arbitration, call and return sequencing
// How it works
// - Trigger field bits 7-6: 00 low level, 01 fall, 10 rise, 11 both.
// - One trigger setting applies identically to every shared external channel.
// - Edge-mode channel pending flags set by hardware, cleared only by software.
// - Taking an interrupt pushes the program counter, then loads the vector.
// - Level is high bit and low bit together, 00 lowest, 11 highest.
// - Overload NMI outranks every source, has no priority bits.
// - Only a strictly higher level may preempt a running service routine.
// - A level 3 routine is never preempted by a maskable source.
// - Simultaneous requests of different level: higher level wins.
// - Equal levels are resolved by fixed polling order.
// - Requests sampled on rising edge, polled in each fetch cycle.
// - No call while equal or higher level routine is in progress.
// - Vectoring only in the final cycle of the current instruction.
// - After a return, one more non-return instruction runs before vectoring.
// - A request gone when blocking ends is dropped; poll sees current requests.
// - Bank 0 bits 6..0 and bank 1 bits 5, 3, 0 map sources.
// - Return clears current in-progress level and pops two stacked bytes.
// - In level mode channel flags follow the pins; writes cannot clear them.
`timescale 1ns/10ps
module piu_core
    import piu_pkg::*;
#(
    parameter int NUM_CHAN = NUM_EXT4,
    parameter logic [7:0] CHAN_MASK = MASK_EXT4
)(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic [8:0] srcReq,
    input wire logic ovlNmiReq,
    input wire logic [7:0] ext4Pins,
    input wire logic fetchCycle,
    input wire logic lastCycle,
    input wire logic retiInProgress,
    output logic seqBusy,
    output logic stackPushLo,
    output logic stackPushHi,
    output logic pcLoadVec,
    output logic stackPopHi,
    output logic stackPopLo,
    output logic [15:0] vecAddr,
    output logic [2:0] activeRank
);
    // Refuse any channel count other than the 8 bits of the flag register
    if (NUM_CHAN != NUM_EXT4) begin : g_bad_chan
        $error("piu_core: NUM_CHAN must equal the 8-bit flag register");
    end

    // Rank of a source from its two priority bits
    function automatic logic [2:0] rankOf(input logic hi, input logic lo);
        rankOf = {1'b0, hi, lo} + 3'h1;
    endfunction : rankOf

    logic [7:0] prioHigh0_q;
    logic [7:0] prioHigh1_q;
    logic [7:0] prioLow0_q;
    logic [7:0] prioLow1_q;
    logic [1:0] trigMode_q;
    logic [7:0] rdData_q;
    logic [7:0] rdData_d;
    logic [NUM_CHAN-1:0] ext4Flags;
    logic ext4Any;
    logic [NUM_SRC-1:0] reqAll;
    logic [NUM_SRC-1:0] reqSample_q;
    logic nmiSample_q;
    logic [NUM_SRC-1:0] srcHigh;
    logic [NUM_SRC-1:0] srcLow;
    logic [2:0] srcRank [NUM_SRC];
    logic [2:0] winRank;
    logic [3:0] winIdx;
    logic [RANK_NMI:1] active_q;
    logic [RANK_NMI:1] active_d;
    logic [2:0] curRank;
    logic callGo;
    logic retiDone;
    logic [15:0] vecAddr_q;
    piu_seq_t seq_q;
    piu_seq_t seq_d;
    logic wrPend;
    logic wrHigh0;
    logic wrHigh1;
    logic wrLow0;
    logic wrLow1;
    logic wrTrig;

    // Address decode for writes
    assign wrHigh0 = regWr && (regAddr == ADDR_PRIO_HIGH0);
    assign wrHigh1 = regWr && (regAddr == ADDR_PRIO_HIGH1);
    assign wrLow0 = regWr && (regAddr == ADDR_PRIO_LOW0);
    assign wrLow1 = regWr && (regAddr == ADDR_PRIO_LOW1);
    assign wrPend = regWr && (regAddr == ADDR_EXT4_PEND);
    assign wrTrig = regWr && (regAddr == ADDR_EXT4_TRIG);

    // Read mux; unmapped addresses and reserved bits read zero
    assign rdData_d =
        (regAddr == ADDR_PRIO_HIGH0) ? (prioHigh0_q & MASK_PRIO0) :
        (regAddr == ADDR_PRIO_HIGH1) ? (prioHigh1_q & MASK_PRIO1) :
        (regAddr == ADDR_PRIO_LOW0) ? (prioLow0_q & MASK_PRIO0) :
        (regAddr == ADDR_PRIO_LOW1) ? (prioLow1_q & MASK_PRIO1) :
        (regAddr == ADDR_EXT4_PEND) ? (ext4Flags & CHAN_MASK) :
        (regAddr == ADDR_EXT4_TRIG) ? {trigMode_q, 6'h00} : REG_RESET;

    // Software registers; reserved bits never store
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prioHigh0_q <= REG_RESET;
            prioHigh1_q <= REG_RESET;
            prioLow0_q <= REG_RESET;
            prioLow1_q <= REG_RESET;
            trigMode_q <= TRIG_RESET;
        end else begin
            if (wrHigh0) prioHigh0_q <= regWrData & MASK_PRIO0;
            if (wrHigh1) prioHigh1_q <= regWrData & MASK_PRIO1;
            if (wrLow0) prioLow0_q <= regWrData & MASK_PRIO0;
            if (wrLow1) prioLow1_q <= regWrData & MASK_PRIO1;
            if (wrTrig) trigMode_q <= regWrData[TRIG_MSB:TRIG_LSB];
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdData_q <= REG_RESET;
        end else begin
            rdData_q <= regRd ? rdData_d : REG_RESET;
        end
    end
    assign regRdData = rdData_q;

    // Shared external channels, all fed the same trigger mode
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        if (CHAN_MASK[c]) begin : g_on
            piu_ext4_chan u_chan (
                .clk(clk),
                .sys_rst(sys_rst),
                .sampleEn(fetchCycle),
                .pinLevel(ext4Pins[c]),
                .trigMode(trigMode_q),
                .swWrite(wrPend),
                .swData(regWrData[c]),
                .pending(ext4Flags[c])
            );
        end else begin : g_off
            assign ext4Flags[c] = 1'b0;
        end
    end
    assign ext4Any = |ext4Flags;

    // Request vector in polling order; shared channels sit at their slot
    assign reqAll = {srcReq[8], ext4Any, srcReq[7:0]};

    // Register requests each rising edge; polled only at fetch
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reqSample_q <= '0;
            nmiSample_q <= 1'b0;
        end else begin
            reqSample_q <= reqAll;
            nmiSample_q <= ovlNmiReq;
        end
    end

    // Priority bits gathered per source
    assign srcHigh = {prioHigh1_q[PRIO1_PWM_BIT], prioHigh1_q[PRIO1_EXT4_BIT],
                      prioHigh1_q[PRIO1_SPI_BIT], prioHigh0_q[6:0]};
    assign srcLow = {prioLow1_q[PRIO1_PWM_BIT], prioLow1_q[PRIO1_EXT4_BIT],
                     prioLow1_q[PRIO1_SPI_BIT], prioLow0_q[6:0]};
    for (genvar s = 0; s < NUM_SRC; s++) begin : g_rank
        assign srcRank[s] = rankOf(srcHigh[s], srcLow[s]);
    end

    // Highest rank wins; walking downward lets the earlier source win ties
    always_comb begin
        winRank = RANK_NONE;
        winIdx = 4'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (reqSample_q[i] && (srcRank[i] >= winRank)) begin
                winRank = srcRank[i];
                winIdx = 4'(i);
            end
        end
        if (nmiSample_q) begin
            winRank = RANK_NMI;
            winIdx = SRC_NMI;
        end
    end

    // Highest level currently in service
    always_comb begin
        curRank = RANK_NONE;
        for (int r = 1; r <= RANK_NMI; r++) begin
            if (active_q[r]) curRank = 3'(r);
        end
    end
    assign activeRank = curRank;

    // Call only at a fetch in the last cycle of a non-return instruction
    assign callGo = (seq_q == SEQ_IDLE) && fetchCycle && lastCycle
                    && !retiInProgress
                    && (winRank > curRank);
    assign retiDone = (seq_q == SEQ_IDLE) && lastCycle && retiInProgress;

    // In-progress levels: set on call, drop highest on return
    always_comb begin
        active_d = active_q;
        if (callGo) begin
            active_d[winRank] = 1'b1;
        end else if (retiDone && (curRank != RANK_NONE)) begin
            active_d[curRank] = 1'b0;
        end
    end

    // Sequencer next state
    always_comb begin
        seq_d = seq_q;
        unique case (seq_q)
            SEQ_IDLE: begin
                if (callGo) seq_d = SEQ_PUSH_LO;
                else if (retiDone) seq_d = SEQ_POP_HI;
            end
            SEQ_PUSH_LO: seq_d = SEQ_PUSH_HI;
            SEQ_PUSH_HI: seq_d = SEQ_LOAD;
            SEQ_LOAD: seq_d = SEQ_IDLE;
            SEQ_POP_HI: seq_d = SEQ_POP_LO;
            SEQ_POP_LO: seq_d = SEQ_IDLE;
            default: seq_d = SEQ_IDLE;
        endcase
    end

    // State, level and vector registers; vector is frozen for the whole call
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seq_q <= SEQ_IDLE;
            active_q <= '0;
            vecAddr_q <= VEC_RESET;
        end else begin
            seq_q <= seq_d;
            active_q <= active_d;
            if (callGo) vecAddr_q <= VEC_TABLE[winIdx];
        end
    end

    // Stack strobes: push low then high byte before the vector load
    assign stackPushLo = (seq_q == SEQ_PUSH_LO);
    assign stackPushHi = (seq_q == SEQ_PUSH_HI);
    assign pcLoadVec = (seq_q == SEQ_LOAD);
    assign stackPopHi = (seq_q == SEQ_POP_HI);
    assign stackPopLo = (seq_q == SEQ_POP_LO);
    assign seqBusy = (seq_q != SEQ_IDLE);
    assign vecAddr = vecAddr_q;

    // Checks of the documented behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_push;
        stackPushLo ##1 stackPushHi ##1 pcLoadVec ##1 !seqBusy;
    endsequence
    sequence s_pop;
        stackPopHi ##1 stackPopLo ##1 !seqBusy;
    endsequence

    property p_trig_write;
        wrTrig |=> (trigMode_q == $past(regWrData[TRIG_MSB:TRIG_LSB]));
    endproperty
    a_trig_write: assert property (p_trig_write)
        else $error("trigger mode not taken from bits 7-6");

    property p_same_mode;
        (trigMode_q == TRIG_LOW) && CHAN_MASK[0] && CHAN_MASK[1]
            |=> (ext4Flags[0] == !$past(ext4Pins[0]))
                && (ext4Flags[1] == !$past(ext4Pins[1]));
    endproperty
    a_same_mode: assert property (p_same_mode)
        else $error("channels do not share the low level mode");

    property p_level_follow;
        (trigMode_q == TRIG_LOW) && wrPend && !ext4Pins[0] && CHAN_MASK[0]
            |=> ext4Flags[0];
    endproperty
    a_level_follow: assert property (p_level_follow)
        else $error("level mode flag cleared by a write");

    property p_flag_sticky;
        (trigMode_q != TRIG_LOW) && ext4Flags[0] && !wrPend && !$rose(sys_rst)
            |=> ext4Flags[0];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("edge flag dropped without software clear");

    property p_call_seq;
        callGo |=> s_push;
    endproperty
    a_call_seq: assert property (p_call_seq)
        else $error("push and vector load out of order");

    property p_reti_seq;
        retiDone |=> s_pop;
    endproperty
    a_reti_seq: assert property (p_reti_seq)
        else $error("return did not pop two bytes");

    property p_reti_level;
        retiDone && !callGo |=> (curRank < $past(curRank))
            || ($past(curRank) == RANK_NONE);
    endproperty
    a_reti_level: assert property (p_reti_level)
        else $error("return left the level in progress");

    property p_higher_only;
        stackPushLo |-> (curRank > $past(curRank));
    endproperty
    a_higher_only: assert property (p_higher_only)
        else $error("call at equal or lower level than in service");

    property p_top_level;
        (curRank == RANK_L3) && !nmiSample_q |-> !callGo;
    endproperty
    a_top_level: assert property (p_top_level)
        else $error("level 3 routine preempted");

    property p_final_cycle;
        stackPushLo |-> $past(lastCycle) && $past(fetchCycle) && !$past(retiInProgress);
    endproperty
    a_final_cycle: assert property (p_final_cycle)
        else $error("vectored outside an instruction's final cycle");

    property p_nmi_vec;
        callGo && nmiSample_q |=> (vecAddr == VEC_TABLE[SRC_NMI]);
    endproperty
    a_nmi_vec: assert property (p_nmi_vec)
        else $error("overload NMI not given its vector");
endmodule : piu_core

// ---- testbench/piu_cpu_model.sv ----
// CPU sequencer model facing the prioritized interrupt unit
`timescale 1ns/10ps
module piu_cpu_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic instrEnd,
    input wire logic instrReti,
    input wire logic seqBusy,
    input wire logic stackPushLo,
    input wire logic stackPushHi,
    input wire logic pcLoadVec,
    input wire logic stackPopHi,
    input wire logic stackPopLo,
    output logic fetchCycle,
    output logic lastCycle,
    output logic retiInProgress,
    output logic protoErr
);
    logic [4:0] prevStrobe_q;

    // One clock per machine cycle, so every cycle carries a fetch
    assign fetchCycle = 1'b1;
    // Instruction ends are masked, not deferred, while a call or return sequence runs
    assign lastCycle = instrEnd && !seqBusy;
    assign retiInProgress = instrReti && !seqBusy;

    // Stack order watch: a step without its predecessor is flagged sticky
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prevStrobe_q <= 5'h00;
            protoErr <= 1'b0;
        end else begin
            prevStrobe_q <= {stackPushLo, stackPushHi, pcLoadVec, stackPopHi, stackPopLo};
            if ((stackPushHi && !prevStrobe_q[4]) || (pcLoadVec && !prevStrobe_q[3])) begin
                protoErr <= 1'b1;
            end
            if (stackPopLo && !prevStrobe_q[1]) begin
                protoErr <= 1'b1;
            end
        end
    end
endmodule : piu_cpu_model

// ---- testbench/test_prioritized_interrupt_unit.sv ----
// Self-checking bench for the prioritized interrupt unit
`timescale 1ns/10ps
module test_prioritized_interrupt_unit;
    import piu_pkg::*;
    logic clk, sys_rst, regWr, regRd, ovlNmiReq, instrEnd, instrReti;
    logic [7:0] regAddr, regWrData, ext4Pins, regRdData;
    logic [8:0] srcReq;
    logic seqBusy, stackPushLo, stackPushHi, pcLoadVec, stackPopHi, stackPopLo;
    logic fetchCycle, lastCycle, retiInProgress, protoErr;
    logic [15:0] vecAddr;
    logic [2:0] activeRank;
    int n_mismatch, tests_run, cycles;

    piu_core piu_core_inst (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .srcReq(srcReq), .ovlNmiReq(ovlNmiReq), .ext4Pins(ext4Pins),
        .fetchCycle(fetchCycle), .lastCycle(lastCycle), .retiInProgress(retiInProgress),
        .seqBusy(seqBusy), .stackPushLo(stackPushLo), .stackPushHi(stackPushHi),
        .pcLoadVec(pcLoadVec), .stackPopHi(stackPopHi), .stackPopLo(stackPopLo),
        .vecAddr(vecAddr), .activeRank(activeRank));

    piu_cpu_model piu_cpu_model_inst (.clk(clk), .sys_rst(sys_rst), .instrEnd(instrEnd),
        .instrReti(instrReti), .seqBusy(seqBusy), .stackPushLo(stackPushLo),
        .stackPushHi(stackPushHi), .pcLoadVec(pcLoadVec), .stackPopHi(stackPopHi),
        .stackPopLo(stackPopLo), .fetchCycle(fetchCycle), .lastCycle(lastCycle),
        .retiInProgress(retiInProgress), .protoErr(protoErr));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        chk(regRdData, exp);
    endtask : rd

    task automatic set_req(input logic [8:0] s, input logic nmi);
        @(posedge clk);
        srcReq <= s;
        ovlNmiReq <= nmi;
    endtask : set_req

    // One final cycle of an instruction, optionally a return
    task automatic end_instr(input logic reti);
        @(posedge clk);
        instrEnd <= 1'b1;
        instrReti <= reti;
        @(posedge clk);
        instrEnd <= 1'b0;
        instrReti <= 1'b0;
    endtask : end_instr

    task automatic expect_call(input logic [15:0] v, input logic [2:0] r);
        @(negedge clk);
        chk({stackPushLo, stackPushHi, pcLoadVec}, 3'h4);
        chk(vecAddr, v);
        chk(activeRank, r);
        @(negedge clk);
        chk({stackPushLo, stackPushHi, pcLoadVec}, 3'h2);
        @(negedge clk);
        chk({stackPushLo, stackPushHi, pcLoadVec}, 3'h1);
        @(negedge clk);
        chk(seqBusy, 1'b0);
    endtask : expect_call

    // Pops high then low; no call may start in the return's own cycle
    task automatic expect_ret(input logic [2:0] r);
        @(negedge clk);
        chk({stackPushLo, stackPopHi, stackPopLo}, 3'h2);
        @(negedge clk);
        chk({stackPushLo, stackPopHi, stackPopLo}, 3'h1);
        @(negedge clk);
        chk(activeRank, r);
    endtask : expect_ret

    task automatic expect_none();
        repeat (4) begin
            @(negedge clk);
            chk({stackPushLo, stackPushHi, pcLoadVec, stackPopHi, stackPopLo}, 5'h00);
        end
    endtask : expect_none

    task automatic t_regs();
        logic [7:0] a [5] = '{ADDR_PRIO_HIGH0, ADDR_PRIO_HIGH1, ADDR_PRIO_LOW0,
            ADDR_PRIO_LOW1, ADDR_EXT4_TRIG};
        logic [7:0] m [5] = '{8'h7f, 8'h29, 8'h7f, 8'h29, 8'hc0};
        chk(activeRank, 3'h0);
        chk(vecAddr, 16'h0000);
        rd(ADDR_EXT4_PEND, 8'h00);
        rd(8'h42, 8'h00);
        for (int i = 0; i < 5; i++) begin
            rd(a[i], 8'h00);
            wr(a[i], 8'hff);
            rd(a[i], m[i]);
            wr(a[i], 8'h00);
        end
    endtask : t_regs

    // Each trigger code: drop pins 0,4,5,7, clear, raise them again
    task automatic t_ext4();
        logic [7:0] onLow [4] = '{8'h21, 8'h21, 8'h00, 8'h21};
        logic [7:0] afterClr [4] = '{8'h21, 8'h00, 8'h00, 8'h00};
        logic [7:0] onHigh [4] = '{8'h00, 8'h00, 8'h21, 8'h21};
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_EXT4_TRIG, {i[1:0], 6'h00});
            set_req(9'h000, 1'b0);
            ext4Pins <= 8'h4e;
            repeat (3) @(posedge clk);
            rd(ADDR_EXT4_PEND, onLow[i]);
            wr(ADDR_EXT4_PEND, 8'h00);
            rd(ADDR_EXT4_PEND, afterClr[i]);
            set_req(9'h000, 1'b0);
            ext4Pins <= 8'hff;
            repeat (3) @(posedge clk);
            rd(ADDR_EXT4_PEND, onHigh[i]);
            wr(ADDR_EXT4_PEND, 8'h00);
        end
        // Software may set edge-mode flags directly
        wr(ADDR_EXT4_PEND, 8'hff);
        rd(ADDR_EXT4_PEND, 8'h6f);
        wr(ADDR_EXT4_PEND, 8'h00);
        // Both-edge mode: a low pulse on pins 0,4,5,7 raises the shared request
        set_req(9'h000, 1'b0);
        ext4Pins <= 8'h4e;
        repeat (3) @(posedge clk);
        set_req(9'h000, 1'b0);
        ext4Pins <= 8'hff;
        repeat (3) @(posedge clk);
        end_instr(1'b0);
        expect_call(16'h0053, 3'h1);
        // Vectoring leaves the channel flags for software to clear
        rd(ADDR_EXT4_PEND, 8'h21);
        wr(ADDR_EXT4_PEND, 8'h00);
        rd(ADDR_EXT4_PEND, 8'h00);
        // Pulse again inside the routine; equal level must wait
        set_req(9'h000, 1'b0);
        ext4Pins <= 8'h4e;
        repeat (3) @(posedge clk);
        set_req(9'h000, 1'b0);
        ext4Pins <= 8'hff;
        repeat (3) @(posedge clk);
        end_instr(1'b1);
        expect_ret(3'h0);
        end_instr(1'b0);
        expect_call(16'h0053, 3'h1);
        rd(ADDR_EXT4_PEND, 8'h21);
        wr(ADDR_EXT4_PEND, 8'h00);
        end_instr(1'b1);
        expect_ret(3'h0);
        wr(ADDR_EXT4_TRIG, 8'h00);
    endtask : t_ext4

    task automatic t_block();
        set_req(9'h008, 1'b0);
        expect_none();
        set_req(9'h000, 1'b0);
        end_instr(1'b0);
        expect_none();
    endtask : t_block

    // Priority writes only while requests are quiet
    task automatic t_tie();
        set_req(9'h106, 1'b0);
        end_instr(1'b0);
        expect_call(16'h000b, 3'h1);
        set_req(9'h000, 1'b0);
        end_instr(1'b1);
        expect_ret(3'h0);
        wr(ADDR_PRIO_LOW1, 8'h20);
        set_req(9'h106, 1'b0);
        end_instr(1'b0);
        expect_call(16'h0063, 3'h2);
        set_req(9'h000, 1'b0);
        end_instr(1'b1);
        expect_ret(3'h0);
        wr(ADDR_PRIO_HIGH0, 8'h40);
        set_req(9'h146, 1'b0);
        end_instr(1'b0);
        expect_call(16'h0033, 3'h3);
        set_req(9'h000, 1'b0);
        end_instr(1'b1);
        expect_ret(3'h0);
        wr(ADDR_PRIO_HIGH0, 8'h00);
        wr(ADDR_PRIO_LOW1, 8'h00);
    endtask : t_tie

    task automatic t_nest();
        wr(ADDR_PRIO_HIGH1, 8'h01);
        wr(ADDR_PRIO_LOW1, 8'h01);
        set_req(9'h081, 1'b0);
        end_instr(1'b0);
        expect_call(16'h003b, 3'h4);
        end_instr(1'b0);
        expect_none();
        set_req(9'h081, 1'b1);
        end_instr(1'b0);
        expect_call(16'h007b, 3'h5);
        set_req(9'h001, 1'b0);
        end_instr(1'b1);
        expect_ret(3'h4);
        end_instr(1'b0);
        expect_none();
        end_instr(1'b1);
        expect_ret(3'h0);
        end_instr(1'b0);
        expect_call(16'h0003, 3'h1);
        set_req(9'h000, 1'b0);
        end_instr(1'b1);
        expect_ret(3'h0);
        wr(ADDR_PRIO_HIGH1, 8'h00);
        wr(ADDR_PRIO_LOW1, 8'h00);
    endtask : t_nest

    // Main sequence
    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        srcReq = 9'h000;
        ovlNmiReq = 1'b0;
        ext4Pins = 8'hff;
        instrEnd = 1'b0;
        instrReti = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        cycles = 0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_ext4();
        t_block();
        t_tie();
        t_nest();
        chk(protoErr, 1'b0);
        wrap_up();
    end
endmodule : test_prioritized_interrupt_unit
